/* File: logic/udr_params.svh */
// Purpose: constants for the serial channel dma request block
// Assumes: included by the package and the design file
// Notes: receiver clock cycles counted as baud ticks
`ifndef UDR_PARAMS_SVH
`define UDR_PARAMS_SVH
`define UDR_FIFO_DEPTH 16
`define UDR_RX_INTERVAL_RCLK 3
`define UDR_RX_TIMEOUT_INTERVAL_RCLK 8
`define UDR_BAUD_DIV 16'h0010
`endif

/* File: logic/udr_pkg.sv */
// Purpose: types for the dma request block
// Assumes: udr_params.svh holds the numbers
// Notes: none
`include "udr_params.svh"
package udr_pkg;
   typedef struct packed {
      logic fifo_enable_bit;
      logic dma_mode_select_bit;
   } udr_cfg_s;
   typedef struct packed {
      logic tx_dma_request_n;
      logic rx_dma_request_n;
   } udr_req_s;
   typedef enum logic [2:0] {
      RX_IDLE = 3'h1,
      RX_WAIT = 3'h2,
      RX_REQ = 3'h4
   } udr_rx_e;
endpackage : udr_pkg

/* File: logic/udr_dma_ready.sv */
// Purpose: transmit and receive dma request outputs of one serial channel
// Assumes: fifo levels, load and timeout events come from the channel, in CLK_I domain
// Notes: outputs are active low with separate output enables for float
`timescale 1ns/1ps
`include "udr_params.svh"
module udr_dma_ready #(
   parameter int DEPTH = `UDR_FIFO_DEPTH,
   parameter int CW = $clog2(DEPTH + 1)
) (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire udr_pkg::udr_cfg_s CFG_I,
   input wire logic [15:0] BAUD_DIV_I,
   input wire logic [CW-1:0] TX_LEVEL_I,
   input wire logic TX_LOAD_I,
   input wire logic [CW-1:0] RX_LEVEL_I,
   input wire logic RX_TRIGGER_I,
   input wire logic RX_TIMEOUT_I,
   input wire logic FLOAT_I,
   output udr_pkg::udr_req_s REQ_O,
   output udr_pkg::udr_req_s REQ_OE_O
);
   import udr_pkg::*;

   localparam logic [3:0] RX_INT = 4'(`UDR_RX_INTERVAL_RCLK);
   localparam logic [3:0] RX_TO_INT = 4'(`UDR_RX_TIMEOUT_INTERVAL_RCLK);

   wire mode1 = CFG_I.fifo_enable_bit & CFG_I.dma_mode_select_bit;
   wire tx_empty = (TX_LEVEL_I == '0);
   wire tx_full = (TX_LEVEL_I == CW'(DEPTH));
   wire rx_empty = (RX_LEVEL_I == '0);

   // receiver clock tick
   logic [15:0] baud_q;
   wire [15:0] div = (BAUD_DIV_I == 16'h0000) ? `UDR_BAUD_DIV : BAUD_DIV_I;
   wire rclk_tick = (baud_q == 16'h0000);
   always_ff @(posedge CLK_I) begin
      if (SRST_I) baud_q <= 16'h0000;
      else if (rclk_tick) baud_q <= div - 16'h0001;
      else baud_q <= baud_q - 16'h0001;
   end

   // transmit request, active low
   logic tx_n_q;
   logic tx_n_d;
   always_comb begin
      tx_n_d = tx_n_q;
      if (mode1) begin
         if (tx_empty) tx_n_d = 1'b0;
         else if (tx_full) tx_n_d = 1'b1;
      end else begin
         if (TX_LOAD_I || !tx_empty) tx_n_d = 1'b1;
         else tx_n_d = 1'b0;
      end
   end
   always_ff @(posedge CLK_I) begin
      if (SRST_I) tx_n_q <= 1'b0;
      else tx_n_q <= tx_n_d;
   end

   // receive request, with rclk delay only when the fifo is enabled
   udr_rx_e st_q;
   udr_rx_e st_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   wire rx_cause = mode1 ? (RX_TRIGGER_I | RX_TIMEOUT_I) : !rx_empty;
   wire [3:0] interval = (CFG_I.fifo_enable_bit && RX_TIMEOUT_I) ? RX_TO_INT : RX_INT;
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      unique case (st_q)
         RX_IDLE: begin
            if (rx_cause && !rx_empty) begin
               st_d = CFG_I.fifo_enable_bit ? RX_WAIT : RX_REQ;
               cnt_d = interval;
            end
         end
         RX_WAIT: begin
            if (rx_empty) st_d = RX_IDLE;
            else if (rclk_tick) begin
               if (cnt_q <= 4'h1) st_d = RX_REQ;
               else cnt_d = cnt_q - 4'h1;
            end
         end
         RX_REQ: begin
            if (rx_empty) st_d = RX_IDLE;
         end
         default: st_d = RX_IDLE;
      endcase
   end
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         st_q <= RX_IDLE;
         cnt_q <= 4'h0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
      end
   end

   // one driver per output port, struct order tx then rx
   wire rx_n = (st_q != RX_REQ);
   assign REQ_O = {tx_n_q, rx_n};
   assign REQ_OE_O = {2{!FLOAT_I}};

   // check helpers: ticks seen while waiting, interval taken at entry
   logic [3:0] chk_ticks_q;
   logic [3:0] chk_need_q;
   always_ff @(posedge CLK_I) begin
      if (SRST_I || st_q != RX_WAIT) chk_ticks_q <= 4'h0;
      else if (rclk_tick) chk_ticks_q <= chk_ticks_q + 4'h1;
   end
   always_ff @(posedge CLK_I) begin
      if (SRST_I) chk_need_q <= 4'h0;
      else if (st_q == RX_IDLE) chk_need_q <= interval;
   end

   property p_float;
      @(posedge CLK_I) FLOAT_I |-> (REQ_OE_O == 2'b00);
   endproperty
   a_float: assert property (p_float) else $error("outputs not released");

   property p_m0_tx_low;
      @(posedge CLK_I) disable iff (SRST_I)
         (!mode1 && tx_empty && !TX_LOAD_I) |=> !REQ_O.tx_dma_request_n;
   endproperty
   a_m0_tx_low: assert property (p_m0_tx_low) else $error("mode0 tx not low");

   property p_m0_tx_high;
      @(posedge CLK_I) disable iff (SRST_I)
         (!mode1 && TX_LOAD_I) |=> REQ_O.tx_dma_request_n;
   endproperty
   a_m0_tx_high: assert property (p_m0_tx_high) else $error("mode0 tx not high");

   property p_m1_tx_low;
      @(posedge CLK_I) disable iff (SRST_I) (mode1 && tx_empty) |=> !REQ_O.tx_dma_request_n;
   endproperty
   a_m1_tx_low: assert property (p_m1_tx_low) else $error("mode1 tx not low");

   property p_m1_tx_high;
      @(posedge CLK_I) disable iff (SRST_I) (mode1 && tx_full) |=> REQ_O.tx_dma_request_n;
   endproperty
   a_m1_tx_high: assert property (p_m1_tx_high) else $error("mode1 tx not high");

   property p_m1_tx_hold;
      @(posedge CLK_I) disable iff (SRST_I)
         (mode1 && !tx_full && !tx_empty && !REQ_O.tx_dma_request_n)
         |=> !REQ_O.tx_dma_request_n;
   endproperty
   a_m1_tx_hold: assert property (p_m1_tx_hold) else $error("mode1 tx released early");

   property p_rx_empty;
      @(posedge CLK_I) disable iff (SRST_I) rx_empty |=> REQ_O.rx_dma_request_n;
   endproperty
   a_rx_empty: assert property (p_rx_empty) else $error("rx req while empty");

   property p_rx_m0_nofifo;
      @(posedge CLK_I) disable iff (SRST_I)
         (!CFG_I.fifo_enable_bit && !rx_empty && st_q == RX_IDLE) |=> !REQ_O.rx_dma_request_n;
   endproperty
   a_rx_m0_nofifo: assert property (p_rx_m0_nofifo) else $error("rx req late");

   property p_rx_wait;
      @(posedge CLK_I) disable iff (SRST_I)
         (st_q == RX_IDLE && st_d == RX_WAIT) |=> REQ_O.rx_dma_request_n;
   endproperty
   a_rx_wait: assert property (p_rx_wait) else $error("rx req without interval");

   sequence s_rx_enter;
      (st_q == RX_IDLE) && (st_d == RX_WAIT);
   endsequence

   sequence s_rx_last_tick;
      (st_q == RX_WAIT) && !rx_empty && rclk_tick && (chk_ticks_q + 4'h1 == chk_need_q);
   endsequence

   property p_rx_need_to;
      @(posedge CLK_I) disable iff (SRST_I)
         s_rx_enter ##0 RX_TIMEOUT_I |=> (chk_need_q == RX_TO_INT);
   endproperty
   a_rx_need_to: assert property (p_rx_need_to) else $error("timeout interval wrong");

   property p_rx_need;
      @(posedge CLK_I) disable iff (SRST_I)
         s_rx_enter ##0 !RX_TIMEOUT_I |=> (chk_need_q == RX_INT);
   endproperty
   a_rx_need: assert property (p_rx_need) else $error("receive interval wrong");

   property p_rx_early;
      @(posedge CLK_I) disable iff (SRST_I)
         ((st_q == RX_WAIT) && !(rclk_tick && (chk_ticks_q + 4'h1 == chk_need_q)))
         |=> REQ_O.rx_dma_request_n;
   endproperty
   a_rx_early: assert property (p_rx_early) else $error("rx req before interval");

   property p_rx_done;
      @(posedge CLK_I) disable iff (SRST_I) s_rx_last_tick |=> !REQ_O.rx_dma_request_n;
   endproperty
   a_rx_done: assert property (p_rx_done) else $error("rx req late after interval");

   property p_rx_m1_cause;
      @(posedge CLK_I) disable iff (SRST_I)
         (mode1 && st_q == RX_IDLE && !RX_TRIGGER_I && !RX_TIMEOUT_I) |=> REQ_O.rx_dma_request_n;
   endproperty
   a_rx_m1_cause: assert property (p_rx_m1_cause) else $error("mode1 rx req uncaused");

   property p_rx_stands;
      @(posedge CLK_I) disable iff (SRST_I)
         (!REQ_O.rx_dma_request_n && !rx_empty) |=> !REQ_O.rx_dma_request_n;
   endproperty
   a_rx_stands: assert property (p_rx_stands) else $error("rx req dropped early");

   property p_tx_nofifo;
      @(posedge CLK_I) disable iff (SRST_I)
         (!CFG_I.fifo_enable_bit && tx_empty && !TX_LOAD_I) |=> !REQ_O.tx_dma_request_n;
   endproperty
   a_tx_nofifo: assert property (p_tx_nofifo) else $error("tx req not mode0");

   property p_drive;
      @(posedge CLK_I) !FLOAT_I |-> (REQ_OE_O == 2'b11);
   endproperty
   a_drive: assert property (p_drive) else $error("outputs not driven");
endmodule : udr_dma_ready

/* File: sim/udr_dma_model.sv */
// Purpose: dma controller that fills the transmit path on request
// Assumes: one bus transfer at most every third cycle
// Notes: clr_i empties the modelled transmit fifo
`timescale 1ns/1ps
module udr_dma_model #(
   parameter int CW = 5
) (
   input wire logic clk_i,
   input wire logic clr_i,
   input wire logic go_i,
   input wire logic req_n_i,
   output logic load_o,
   output logic [CW-1:0] level_o
);
   logic gap_q;
   always_ff @(posedge clk_i) begin
      if (clr_i) begin
         load_o <= 1'b0;
         gap_q <= 1'b0;
         level_o <= '0;
      end else begin
         load_o <= go_i && !req_n_i && !load_o && !gap_q;
         gap_q <= load_o;
         level_o <= level_o + CW'(load_o);
      end
   end
endmodule : udr_dma_model

/* File: sim/tb_uart_dma_ready_signaling.sv */
// Purpose: self-checking bench of the dma request block
// Assumes: model fills the transmit fifo, bench drives receive side
// Notes: receive delays checked within one receiver clock
`timescale 1ns/1ps
`include "udr_params.svh"
module tb_uart_dma_ready_signaling;
   import udr_pkg::*;
   localparam int D = `UDR_BAUD_DIV;
   localparam int N3 = `UDR_RX_INTERVAL_RCLK;
   localparam int N8 = `UDR_RX_TIMEOUT_INTERVAL_RCLK;
   localparam int D2 = 8;
   logic [15:0] bdiv = 16'(D);
   logic clk = 1'b0, srst = 1'b1, flt = 1'b0, trig = 1'b0, tmo = 1'b0, go = 1'b0, clr = 1'b1;
   logic load;
   logic [4:0] txl, rxl = '0;
   udr_cfg_s cfg = '0;
   udr_req_s req, oe;
   int fails = 0, n_compared = 0;
   initial forever #4 clk = ~clk;
   udr_dma_ready u_udr_dma_ready (.CLK_I(clk), .SRST_I(srst), .CFG_I(cfg), .BAUD_DIV_I(bdiv),
      .TX_LEVEL_I(txl), .TX_LOAD_I(load), .RX_LEVEL_I(rxl), .RX_TRIGGER_I(trig),
      .RX_TIMEOUT_I(tmo), .FLOAT_I(flt), .REQ_O(req), .REQ_OE_O(oe));
   udr_dma_model u_udr_dma_model (.clk_i(clk), .clr_i(clr), .go_i(go),
      .req_n_i(req.tx_dma_request_n), .load_o(load), .level_o(txl));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up
   task automatic t_tx(input udr_cfg_s c, input logic [7:0] lvl);
      cfg = c;
      clr = 1'b1;
      go = 1'b0;
      cyc(3);
      clr = 1'b0;
      chk("tx_n empty", 8'h0, 8'(req.tx_dma_request_n));
      go = 1'b1;
      cyc(80);
      chk("tx level", lvl, 8'(txl));
      chk("tx_n loaded", 8'h1, 8'(req.tx_dma_request_n));
      $display("tx test done");
   endtask : t_tx
   task automatic t_rx(input udr_cfg_s c, input logic tr, input logic to, input int lo,
      input int hi);
      int n;
      cfg = c;
      trig = tr;
      tmo = to;
      rxl = 5'h1;
      n = 0;
      while (req.rx_dma_request_n !== 1'b0 && n < 200) begin
         cyc(1);
         n++;
      end
      chk("rx_n delay in range", 8'h1, 8'(n >= lo && n <= hi));
      if (n == 200 && hi < 200) wrap_up();
      rxl = '0;
      trig = 1'b0;
      tmo = 1'b0;
      cyc(3);
      chk("rx_n empty", 8'h1, 8'(req.rx_dma_request_n));
      $display("rx test done");
   endtask : t_rx
   task automatic t_float;
      flt = 1'b1;
      #1;
      chk("oe float", 8'h0, 8'(oe));
      cyc(5);
      chk("oe held", 8'h0, 8'(oe));
      flt = 1'b0;
      #1;
      chk("oe drive", 8'h3, 8'(oe));
      $display("float test done");
   endtask : t_float
   initial begin
      cyc(6);
      srst = 1'b0;
      t_tx(2'b10, 8'h1);
      t_tx(2'b11, 8'(`UDR_FIFO_DEPTH));
      t_tx(2'b01, 8'h1);
      t_rx(2'b01, 1'b0, 1'b0, 0, 3);
      t_rx(2'b10, 1'b0, 1'b0, (N3 - 1) * D + 2, N3 * D + 1);
      t_rx(2'b11, 1'b1, 1'b0, (N3 - 1) * D + 2, N3 * D + 1);
      bdiv = 16'(D2);
      cyc(D);
      t_rx(2'b11, 1'b1, 1'b0, (N3 - 1) * D2 + 2, N3 * D2 + 1);
      bdiv = 16'h0000;
      cyc(D);
      t_rx(2'b11, 1'b0, 1'b1, (N8 - 1) * D + 2, N8 * D + 1);
      t_rx(2'b11, 1'b0, 1'b0, 200, 200);
      t_float();
      wrap_up();
   end
endmodule : tb_uart_dma_ready_signaling
